// *** smc_spi_ctrl.sv ***
// Serial port mode, select and clock control with register slave
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "smc_regs.svh"
// Behaviour
// - Source select zero: interrupt on receive full
// - Source select one: interrupt on transmit empty
// - Master, auto select off: select held low
// - Master auto select: low per single byte
// - Continuous transfer keeps select low throughout
// - Slave with select enable obeys select pin
// - Overwrite off: new byte dropped when full
// - Overwrite on: new byte replaces unread byte
// - Clock rate codes divide core by 8..64
// - Shared pins, only selected function active
// - Receive read pops one queued byte
// - Mode bit zero slave, one master
module smc_spi_ctrl #(
  parameter int RX_DEPTH = 4
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // AXI4-Lite write
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Serial clock pin
  input wire logic i_sclk,
  output logic o_sclk,
  output logic o_sclk_oe,
  // Data pins
  input wire logic i_mosi,
  output logic o_mosi,
  output logic o_mosi_oe,
  input wire logic i_miso,
  output logic o_miso,
  output logic o_miso_oe,
  // Select pin
  input wire logic i_ss_n,
  output logic o_ss_n,
  output logic o_ss_oe,
  // Interrupt
  output logic o_irq
);
  import smc_pkg::*;
  typedef struct packed {
    smc_cfg_t cfg;
    logic [3:0] ctl;
    logic [1:0] sts;
    logic [1:0] msk;
    logic irq;
    logic awrdy;
    logic wrdy;
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [7:0] w_byte;
    logic w_lane;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] tx_hold;
    logic tx_full;
    logic [7:0] rx_hold;
    logic [3:0][2:0] sync;
    logic [3:0] pin;
    smc_state_t state;
    logic [5:0] div;
    logic [2:0] bits;
    logic [7:0] shreg;
    logic smp;
    logic loaded;
    logic sclk_o;
    logic shout;
    logic ss_n_o;
    logic sclk_oe;
    logic mosi_oe;
    logic miso_oe;
    logic ss_oe;
    logic push;
    logic [7:0] push_data;
    logic pop;
  } smc_top_st_t;
  smc_top_st_t r;
  smc_top_st_t n;
  logic [3:0] pin_in;
  logic act;
  logic mst;
  logic slv;
  logic sel;
  logic rise;
  logic fall;
  logic tx_evt;
  logic done_c;
  logic [1:0] clr;
  logic [5:0] half;
  smc_rxq_if rxq ();

  assign pin_in = {i_ss_n, i_miso, i_mosi, i_sclk};
  assign act = r.ctl[`SMC_CTL_EN] && !r.ctl[`SMC_CTL_PFS];
  assign mst = act && r.ctl[`SMC_CTL_MS];
  assign slv = act && !r.ctl[`SMC_CTL_MS];
  assign sel = !r.cfg.ss_input_enable || !r.pin[PIN_SS];
  assign half = 6'(`SMC_DIV_MIN / 2) << r.cfg.sclk_rate_select;

  always_comb
  begin
    n = r;
    n.push = 1'b0;
    n.pop = 1'b0;
    tx_evt = 1'b0;
    done_c = 1'b0;
    clr = 2'h0;
    // Three-stage pin filter
    for (int i = 0; i < 4; i++)
    begin
      n.sync[i] = {r.sync[i][1:0], pin_in[i]};
      if (r.sync[i][1] == r.sync[i][2])
      begin
        n.pin[i] = r.sync[i][2];
      end
    end
    rise = n.pin[PIN_SCLK] && !r.pin[PIN_SCLK];
    fall = !n.pin[PIN_SCLK] && r.pin[PIN_SCLK];
    // Register writes
    if (i_awvalid && r.awrdy)
    begin
      n.aw_hold = 1'b1;
      n.aw_addr = i_awaddr;
    end
    if (i_wvalid && r.wrdy)
    begin
      n.w_hold = 1'b1;
      n.w_byte = i_wdata[7:0];
      n.w_lane = i_wstrb[0];
    end
    if (r.bvalid && i_bready)
    begin
      n.bvalid = 1'b0;
    end
    if (r.aw_hold && r.w_hold && !r.bvalid)
    begin
      n.aw_hold = 1'b0;
      n.w_hold = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `SMC_RESP_OK;
      case (r.aw_addr)
        `SMC_CFG_OFS:
        begin
          if (r.w_lane)
          begin
            n.cfg = smc_cfg_t'(r.w_byte & `SMC_CFG_WMASK);
          end
        end
        `SMC_CTL_OFS:
        begin
          if (r.w_lane)
          begin
            n.ctl = r.w_byte[3:0];
          end
        end
        `SMC_TX_OFS:
        begin
          if (r.w_lane && !r.tx_full)
          begin
            n.tx_hold = r.w_byte;
            n.tx_full = 1'b1;
          end
        end
        `SMC_RX_OFS:
        begin
          n.bresp = `SMC_RESP_OK;
        end
        `SMC_STS_OFS:
        begin
          clr = r.w_lane ? r.w_byte[1:0] : 2'h0;
        end
        `SMC_MSK_OFS:
        begin
          if (r.w_lane)
          begin
            n.msk = r.w_byte[1:0];
          end
        end
        default:
        begin
          n.bresp = `SMC_RESP_ERR;
        end
      endcase
    end
    n.awrdy = !n.aw_hold && !n.bvalid;
    n.wrdy = !n.w_hold && !n.bvalid;
    // Register reads
    if (r.rvalid && i_rready)
    begin
      n.rvalid = 1'b0;
    end
    if (i_arvalid && r.arrdy)
    begin
      n.rvalid = 1'b1;
      n.rresp = `SMC_RESP_OK;
      n.rdata = 32'h0;
      case (i_araddr)
        `SMC_CFG_OFS:
        begin
          n.rdata[7:0] = r.cfg;
        end
        `SMC_CTL_OFS:
        begin
          n.rdata[3:0] = r.ctl;
        end
        `SMC_TX_OFS:
        begin
          n.rdata[0] = r.tx_full;
        end
        `SMC_RX_OFS:
        begin
          if (!rxq.empty)
          begin
            n.pop = 1'b1;
            n.rx_hold = rxq.head;
          end
          n.rdata[7:0] = n.rx_hold;
        end
        `SMC_STS_OFS:
        begin
          n.rdata[1:0] = r.sts;
        end
        `SMC_MSK_OFS:
        begin
          n.rdata[1:0] = r.msk;
        end
        default:
        begin
          n.rresp = `SMC_RESP_ERR;
        end
      endcase
    end
    n.arrdy = !n.rvalid;
    // Shift engine
    if (!act)
    begin
      n.state = ST_IDLE;
      n.bits = 3'h0;
      n.div = 6'h0;
      n.loaded = 1'b0;
      n.sclk_o = 1'b0;
    end
    else if (mst)
    begin
      n.loaded = 1'b0;
      case (r.state)
        ST_IDLE:
        begin
          if (r.tx_full)
          begin
            n.shreg = r.tx_hold;
            n.tx_full = 1'b0;
            tx_evt = 1'b1;
            n.state = ST_XFER;
            n.div = 6'h0;
            n.bits = 3'h0;
          end
        end
        ST_XFER:
        begin
          n.div = r.div + 6'h01;
          if (r.div == half - 6'h01)
          begin
            n.div = 6'h0;
            n.sclk_o = !r.sclk_o;
            if (!r.sclk_o)
            begin
              n.smp = n.pin[PIN_MISO];
            end
            else
            begin
              n.shreg = {r.shreg[6:0], r.smp};
              n.bits = r.bits + 3'h1;
              if (r.bits == 3'h7)
              begin
                done_c = 1'b1;
                n.push = 1'b1;
                n.push_data = {r.shreg[6:0], r.smp};
                if (r.ctl[`SMC_CTL_CONT] && r.tx_full)
                begin
                  n.shreg = r.tx_hold;
                  n.tx_full = 1'b0;
                  tx_evt = 1'b1;
                end
                else
                begin
                  n.state = ST_GAP;
                end
              end
            end
          end
        end
        ST_GAP:
        begin
          n.div = r.div + 6'h01;
          if (r.div == half - 6'h01)
          begin
            n.div = 6'h0;
            n.state = ST_IDLE;
          end
        end
        default:
        begin
          n.state = ST_IDLE;
        end
      endcase
    end
    else
    begin
      n.state = ST_IDLE;
      n.sclk_o = 1'b0;
      n.div = 6'h0;
      if (!sel)
      begin
        n.bits = 3'h0;
        n.loaded = 1'b0;
      end
      else
      begin
        if (!r.loaded)
        begin
          n.loaded = 1'b1;
          n.shreg = r.tx_full ? r.tx_hold : `SMC_IDLE_BYTE;
          n.tx_full = 1'b0;
          tx_evt = r.tx_full;
        end
        if (rise)
        begin
          n.smp = r.pin[PIN_MOSI];
        end
        if (fall)
        begin
          n.shreg = {r.shreg[6:0], r.smp};
          n.bits = r.bits + 3'h1;
          if (r.bits == 3'h7)
          begin
            n.push = 1'b1;
            n.push_data = {r.shreg[6:0], r.smp};
            n.loaded = 1'b0;
          end
        end
      end
    end
    // Pin drive
    n.shout = n.shreg[7];
    n.sclk_oe = mst;
    n.mosi_oe = mst;
    n.ss_oe = mst;
    n.miso_oe = slv && sel;
    n.ss_n_o = !(mst && (!r.cfg.auto_ss || n.state == ST_XFER));
    // Events and interrupt
    n.sts[`SMC_STS_EVT] = (r.sts[`SMC_STS_EVT] && !clr[`SMC_STS_EVT])
      || (r.cfg.irq_source_select ? tx_evt : n.push);
    n.sts[`SMC_STS_OVR] = (r.sts[`SMC_STS_OVR] && !clr[`SMC_STS_OVR])
      || (r.push && rxq.full && !rxq.pop);
    n.irq = |(n.sts & n.msk);
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      r <= '0;
      r.cfg <= `SMC_CFG_RST;
      r.pin <= `SMC_PIN_RST;
      r.sync[PIN_SS] <= `SMC_SYNC_SS_RST;
      r.ss_n_o <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  assign rxq.push = r.push;
  assign rxq.wdata = r.push_data;
  assign rxq.ovw = r.cfg.rx_overwrite_enable;
  assign rxq.pop = r.pop;

  smc_rx_fifo #(
    .DEPTH(RX_DEPTH)
  ) u_rx_fifo (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .q(rxq)
  );

  assign o_awready = r.awrdy;
  assign o_wready = r.wrdy;
  assign o_bvalid = r.bvalid;
  assign o_bresp = r.bresp;
  assign o_arready = r.arrdy;
  assign o_rvalid = r.rvalid;
  assign o_rdata = r.rdata;
  assign o_rresp = r.rresp;
  assign o_sclk = r.sclk_o;
  assign o_sclk_oe = r.sclk_oe;
  assign o_mosi = r.shout;
  assign o_mosi_oe = r.mosi_oe;
  assign o_miso = r.shout;
  assign o_miso_oe = r.miso_oe;
  assign o_ss_n = r.ss_n_o;
  assign o_ss_oe = r.ss_oe;
  assign o_irq = r.irq;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_srst);

  a_irq_rx_source: assert property (
    r.push && !$past(r.cfg.irq_source_select) |-> r.sts[`SMC_STS_EVT])
    else $error("receive byte did not flag event");
  a_irq_tx_source: assert property (
    $fell(r.tx_full) && $past(r.cfg.irq_source_select)
    |-> r.sts[`SMC_STS_EVT])
    else $error("transmit empty did not flag event");
  a_ss_manual: assert property (
    mst && !r.cfg.auto_ss |=> !r.ss_n_o)
    else $error("manual select not held low");
  a_ss_byte_low: assert property (
    $past(mst && r.cfg.auto_ss) && r.state == ST_XFER |-> !r.ss_n_o)
    else $error("select high during byte");
  a_ss_byte_end: assert property (
    $past(mst && r.cfg.auto_ss) && r.state == ST_GAP |-> r.ss_n_o)
    else $error("select low after byte");
  a_ss_cont_hold: assert property (
    done_c && mst && r.ctl[`SMC_CTL_CONT] && r.tx_full
    |=> r.state == ST_XFER && !r.ss_n_o)
    else $error("continuous transfer released select");
  a_slave_deselect: assert property (
    slv && r.cfg.ss_input_enable && r.pin[PIN_SS]
    |=> !r.miso_oe && !r.push)
    else $error("deselected slave answered");
  a_sclk_rate_min: assert property (
    $rose(r.sclk_o) && r.cfg.sclk_rate_select == 2'h0
    |=> $stable(r.sclk_o) [*3] ##1 $fell(r.sclk_o))
    else $error("fastest clock half period not four cycles");
  a_pins_released: assert property (
    !act |=> !r.sclk_oe && !r.mosi_oe && !r.miso_oe && !r.ss_oe)
    else $error("inactive port drives a pin");
  a_master_drives: assert property (
    mst |=> r.sclk_oe && r.ss_oe && !r.miso_oe)
    else $error("master pin directions wrong");
  a_slave_no_clock: assert property (
    slv |=> r.state == ST_IDLE && !r.sclk_oe && !r.sclk_o)
    else $error("slave ran the clock divider");
  a_cfg_reserved: assert property (
    i_arvalid && r.arrdy && i_araddr == `SMC_CFG_OFS
    |=> r.rdata[31:6] == 26'h0)
    else $error("reserved bits read nonzero");
  c_master_byte: cover property (done_c && mst);
  c_master_cont: cover property (done_c && r.ctl[`SMC_CTL_CONT] && r.tx_full);
  c_slave_byte: cover property (slv && r.push);
  c_irq_rise: cover property ($rose(r.irq));
endmodule
`default_nettype wire

// *** smc_regs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH
`define SMC_CFG_OFS 8'h00
`define SMC_CTL_OFS 8'h04
`define SMC_TX_OFS 8'h08
`define SMC_RX_OFS 8'h0C
`define SMC_STS_OFS 8'h10
`define SMC_MSK_OFS 8'h14
`define SMC_CFG_RST 8'h10
`define SMC_CFG_WMASK 8'h3F
`define SMC_CTL_MS 0
`define SMC_CTL_CONT 1
`define SMC_CTL_PFS 2
`define SMC_CTL_EN 3
`define SMC_STS_EVT 0
`define SMC_STS_OVR 1
`define SMC_PIN_RST 4'h8
`define SMC_SYNC_SS_RST 3'h7
`define SMC_DIV_MIN 8
`define SMC_IDLE_BYTE 8'hFF
`define SMC_RESP_OK 2'h0
`define SMC_RESP_ERR 2'h2
`endif

// *** smc_pkg.sv ***
// Shared types of the serial port block
`default_nettype none
package smc_pkg;
  typedef struct packed {
    logic [1:0] reserved;
    logic irq_source_select;
    logic auto_ss;
    logic ss_input_enable;
    logic rx_overwrite_enable;
    logic [1:0] sclk_rate_select;
  } smc_cfg_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01,
    ST_GAP = 2'b10
  } smc_state_t;
  typedef enum logic [1:0] {
    PIN_SCLK = 2'b00,
    PIN_MOSI = 2'b01,
    PIN_MISO = 2'b10,
    PIN_SS = 2'b11
  } smc_pin_t;
endpackage
`default_nettype wire

// *** smc_rxq_if.sv ***
// Receive queue link between controller and byte store
`timescale 1ns/1ps
`default_nettype none
interface smc_rxq_if;
  logic push;
  logic ovw;
  logic [7:0] wdata;
  logic pop;
  logic [7:0] head;
  logic full;
  logic empty;
  modport ctl (output push, ovw, wdata, pop, input head, full, empty);
  modport mem (input push, ovw, wdata, pop, output head, full, empty);
endinterface
`default_nettype wire

// *** smc_rx_fifo.sv ***
// Receive byte store with registered head
`timescale 1ns/1ps
`default_nettype none
module smc_rx_fifo #(
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Queue port
  smc_rxq_if.mem q
);
  import smc_pkg::*;
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULLC = CW'(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic [7:0] head;
  } smc_fifo_st_t;
  smc_fifo_st_t r;
  smc_fifo_st_t n;
  logic do_pop;
  logic do_push;
  logic do_ovw;
  logic [AW-1:0] wprev;

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    inc = (p == LAST) ? '0 : p + 1'b1;
  endfunction

  assign wprev = (r.wp == '0) ? LAST : r.wp - 1'b1;

  always_comb
  begin
    n = r;
    do_pop = q.pop && (r.cnt != '0);
    do_push = q.push && ((r.cnt != FULLC) || do_pop);
    do_ovw = q.push && !do_push && q.ovw;
    if (do_pop)
    begin
      n.rp = inc(r.rp);
    end
    if (do_push)
    begin
      n.mem[r.wp] = q.wdata;
      n.wp = inc(r.wp);
    end
    else if (do_ovw)
    begin
      n.mem[wprev] = q.wdata;
    end
    n.cnt = r.cnt + CW'(do_push) - CW'(do_pop);
    n.head = n.mem[n.rp];
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign q.head = r.head;
  assign q.full = (r.cnt == FULLC);
  assign q.empty = (r.cnt == '0);

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_srst);

  a_rx_discard: assert property (
    q.full && q.push && !q.ovw && !q.pop |=> $stable(r.mem) && q.full)
    else $error("full store took a byte with overwrite off");
  a_rx_overwrite: assert property (
    q.full && q.push && q.ovw && !q.pop
    |=> r.mem[$past(wprev)] == $past(q.wdata))
    else $error("overwrite did not replace the newest byte");
  a_rx_pop: assert property (
    q.pop && !q.empty && !q.push |=> r.cnt == $past(r.cnt) - CW'(1))
    else $error("read did not remove one byte");
  c_rx_overwrite: cover property (q.full && q.push && q.ovw);
endmodule
`default_nettype wire

// *** smc_peer.sv ***
// Behavioural far-side serial device, as slave or as master
`timescale 1ns/1ps
`default_nettype none
module smc_peer (
  // Clock
  input wire logic i_clock,
  // Resolved bus wires
  input wire logic i_sclk,
  input wire logic i_ss_n,
  input wire logic i_mosi,
  input wire logic i_miso,
  // Slave reply and master request
  input wire logic [7:0] i_reply,
  input wire logic i_go,
  input wire logic i_use_ss,
  input wire logic [7:0] i_byte,
  // Driven pins
  output logic o_sclk,
  output logic o_ss_n,
  output logic o_mosi,
  output logic o_miso,
  // Observations
  output logic [7:0] o_rx,
  output var int o_cnt,
  output logic o_busy
);
  logic [7:0] sh;
  logic [7:0] rsh;
  int nb;
  int k;
  initial
  begin
    o_sclk = 1'b0;
    o_ss_n = 1'b1;
    o_mosi = 1'b0;
    o_miso = 1'b1;
    o_rx = 8'h00;
    o_cnt = 0;
    o_busy = 1'b0;
    nb = 0;
    rsh = 8'h00;
  end
  // Slave role: reply loaded at select, MSB first
  always @(negedge i_ss_n)
    if (!o_busy)
    begin
      sh = i_reply;
      o_miso = sh[7];
      nb = 0;
    end
  always @(posedge i_sclk)
    if (!i_ss_n && !o_busy)
    begin
      rsh = {rsh[6:0], i_mosi};
      nb = nb + 1;
      if (nb == 8)
      begin
        o_rx = rsh;
        o_cnt = o_cnt + 1;
        nb = 0;
      end
    end
  // Data out changes after the falling clock edge
  always @(negedge i_sclk)
    if (!i_ss_n && !o_busy)
    begin
      sh = (nb == 0) ? i_reply : {sh[6:0], 1'b0};
      o_miso = sh[7];
    end
  // Released line shows the inverse of its last level
  always @(posedge i_ss_n)
    o_miso = ~o_miso;
  // Master role: line clock stands low between frames
  always
  begin
    @(posedge i_clock);
    if (i_go)
    begin
      o_busy <= 1'b1;
      o_ss_n <= ~i_use_ss;
      repeat (8) @(posedge i_clock);
      for (k = 7; k >= 0; k--)
      begin
        o_mosi <= i_byte[k];
        repeat (8) @(posedge i_clock);
        o_sclk <= 1'b1;
        rsh = {rsh[6:0], i_miso};
        repeat (8) @(posedge i_clock);
        o_sclk <= 1'b0;
      end
      repeat (8) @(posedge i_clock);
      o_ss_n <= 1'b1;
      o_mosi <= ~o_mosi;
      o_rx <= rsh;
      o_busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** tb_smc_spi_ctrl.sv ***
// Self-checking bench for the serial port control block
`timescale 1ns/1ps
`default_nettype none
`include "smc_regs.svh"
module tb_smc_spi_ctrl;
  logic i_clock = 1'b0, i_srst = 1'b1, go = 1'b0, use_ss = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, reply = 8'h00, mbyte = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
  logic p_sclk, p_ss_n, p_mosi, p_miso, p_busy;
  logic [7:0] p_rx, st;
  int p_cnt, n_fail = 0, samples_checked = 0, cycles = 0;
  int n_edges, n_ssr, half, c0, r;
  time t_rise;
  wire w_sclk = sclk_oe ? sclk_o : p_sclk;
  wire w_ss = ss_oe ? ss_o : p_ss_n;
  wire w_mosi = mosi_oe ? mosi_o : p_mosi;
  wire w_miso = miso_oe ? miso_o : p_miso;
  smc_spi_ctrl #(.RX_DEPTH(2)) i_smc_spi_ctrl (
    .i_clock(i_clock), .i_srst(i_srst),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hF),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
    .i_sclk(w_sclk), .o_sclk(sclk_o), .o_sclk_oe(sclk_oe),
    .i_mosi(w_mosi), .o_mosi(mosi_o), .o_mosi_oe(mosi_oe),
    .i_miso(w_miso), .o_miso(miso_o), .o_miso_oe(miso_oe),
    .i_ss_n(w_ss), .o_ss_n(ss_o), .o_ss_oe(ss_oe), .o_irq(irq));
  smc_peer i_smc_peer (.i_clock(i_clock), .i_sclk(w_sclk), .i_ss_n(w_ss),
    .i_mosi(w_mosi), .i_miso(w_miso), .i_reply(reply), .i_go(go),
    .i_use_ss(use_ss), .i_byte(mbyte), .o_sclk(p_sclk), .o_ss_n(p_ss_n),
    .o_mosi(p_mosi), .o_miso(p_miso), .o_rx(p_rx), .o_cnt(p_cnt),
    .o_busy(p_busy));
  always #25 i_clock = ~i_clock;
  // Wire monitors: half period, clock edges under select, select releases
  always @(posedge w_sclk)
  begin
    t_rise = $time;
    if (w_ss === 1'b0) n_edges++;
  end
  always @(negedge w_sclk) half = int'(($time - t_rise) / 50);
  always @(posedge w_ss) n_ssr++;
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_fail++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      samples_checked++;
      if (got !== exp)
      begin
        n_fail++;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [7:0] d,
    input logic [1:0] er);
    logic ha, hw, hb;
    begin
      @(posedge i_clock);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      hb = 1'b0;
      while (!hb)
      begin
        @(negedge i_clock);
        ha = awvalid & awready;
        hw = wvalid & wready;
        hb = bvalid;
        if (hb) chk(bresp, er);
        @(posedge i_clock);
        if (ha) awvalid <= 1'b0;
        if (hw) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      repeat (2) @(negedge i_clock);
    end
  endtask
  task automatic axr(input logic [7:0] a, output logic [7:0] d,
    input logic [1:0] er);
    logic ha, hr;
    begin
      @(posedge i_clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      hr = 1'b0;
      while (!hr)
      begin
        @(negedge i_clock);
        ha = arvalid & arready;
        hr = rvalid;
        d = rdata[7:0];
        if (hr) chk({rresp, rdata[31:8]}, {er, 24'h000000});
        @(posedge i_clock);
        if (ha) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      @(negedge i_clock);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    begin
      axr(a, st, 2'h0);
      chk(st, e);
    end
  endtask
  // Master transfer of nb bytes; mid is the event bit expected mid-byte
  task automatic mxfer(input logic [7:0] tx, input int nb, input logic mid);
    int i;
    begin
      axw(`SMC_STS_OFS, 8'h03, 2'h0);
      n_edges = 0;
      n_ssr = 0;
      c0 = p_cnt;
      for (i = 0; i < nb; i++)
      begin
        st = 8'h01;
        while (st[0]) axr(`SMC_TX_OFS, st, 2'h0);
        axw(`SMC_TX_OFS, tx + 8'(i), 2'h0);
        if (i == 0) wait (w_ss === 1'b0);
        if (i == 0) rd(`SMC_STS_OFS, {7'h00, mid});
      end
      wait (p_cnt == c0 + nb);
      repeat (160) @(negedge i_clock);
    end
  endtask
  // Far side acts as master for one byte
  task automatic pxfer(input logic [7:0] b, input logic s);
    begin
      @(posedge i_clock);
      mbyte <= b;
      use_ss <= s;
      go <= 1'b1;
      @(posedge i_clock);
      go <= 1'b0;
      @(posedge i_clock);
      wait (p_busy === 1'b0);
      repeat (20) @(negedge i_clock);
    end
  endtask
  task automatic done(input string s);
    $display("Test %s finished, %0d mismatches so far", s, n_fail);
  endtask
  task automatic final_report();
    begin
      $display("Checked %0d, failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial
  begin
    repeat (6) @(posedge i_clock);
    i_srst <= 1'b0;
    rd(`SMC_CFG_OFS, 8'h10);
    axw(`SMC_CFG_OFS, 8'hFF, 2'h0);
    rd(`SMC_CFG_OFS, 8'h3F);
    axr(8'h20, st, 2'h2);
    axw(8'h20, 8'h01, 2'h2);
    axw(`SMC_MSK_OFS, 8'h03, 2'h0);
    axw(`SMC_CTL_OFS, 8'h09, 2'h0);
    done("registers");
    for (r = 0; r < 4; r++)
    begin
      axw(`SMC_CFG_OFS, 8'h10 | 8'(r), 2'h0);
      reply = 8'hA5 ^ 8'(r);
      mxfer(8'h3C + 8'(r), 1, 1'b0);
      chk(half, 4 << r);
      chk(n_edges, 8);
      chk(n_ssr, 1);
      chk(p_rx, 8'h3C + 8'(r));
      chk(irq, 1'b1);
      rd(`SMC_RX_OFS, 8'hA5 ^ 8'(r));
      axw(`SMC_STS_OFS, 8'h03, 2'h0);
      chk(irq, 1'b0);
    end
    done("rates");
    axw(`SMC_CFG_OFS, 8'h30, 2'h0);
    axw(`SMC_MSK_OFS, 8'h00, 2'h0);
    mxfer(8'h5A, 1, 1'b1);
    chk(irq, 1'b0);
    axw(`SMC_MSK_OFS, 8'h03, 2'h0);
    chk(irq, 1'b1);
    rd(`SMC_RX_OFS, reply);
    done("irq source");
    for (r = 0; r < 2; r++)
    begin
      axw(`SMC_CFG_OFS, 8'h10 | 8'(r << 2), 2'h0);
      reply = 8'h11;
      mxfer(8'h01, 1, 1'b0);
      reply = 8'h22;
      mxfer(8'h02, 1, 1'b0);
      reply = 8'h33;
      mxfer(8'h03, 1, 1'b0);
      rd(`SMC_STS_OFS, 8'h03);
      rd(`SMC_RX_OFS, 8'h11);
      rd(`SMC_RX_OFS, (r == 1) ? 8'h33 : 8'h22);
    end
    done("overwrite");
    axw(`SMC_CFG_OFS, 8'h10, 2'h0);
    axw(`SMC_CTL_OFS, 8'h0B, 2'h0);
    mxfer(8'h50, 2, 1'b0);
    chk(n_edges, 16);
    chk(n_ssr, 1);
    chk(p_rx, 8'h51);
    rd(`SMC_RX_OFS, 8'h33);
    rd(`SMC_RX_OFS, 8'h33);
    axw(`SMC_CTL_OFS, 8'h09, 2'h0);
    axw(`SMC_CFG_OFS, 8'h00, 2'h0);
    chk(w_ss, 1'b0);
    mxfer(8'h66, 1, 1'b0);
    chk(n_ssr, 0);
    chk(p_rx, 8'h66);
    rd(`SMC_RX_OFS, 8'h33);
    done("select control");
    c0 = p_cnt;
    axw(`SMC_CTL_OFS, 8'h0D, 2'h0);
    axw(`SMC_TX_OFS, 8'h77, 2'h0);
    repeat (200) @(negedge i_clock);
    chk({sclk_oe, ss_oe, mosi_oe}, 3'h0);
    chk(p_cnt, c0);
    axw(`SMC_CFG_OFS, 8'h1B, 2'h0);
    axw(`SMC_CTL_OFS, 8'h08, 2'h0);
    axw(`SMC_STS_OFS, 8'h03, 2'h0);
    pxfer(8'h96, 1'b1);
    chk({sclk_oe, ss_oe, mosi_oe}, 3'h0);
    chk(p_rx, 8'h77);
    rd(`SMC_RX_OFS, 8'h96);
    axw(`SMC_STS_OFS, 8'h03, 2'h0);
    pxfer(8'h69, 1'b0);
    rd(`SMC_STS_OFS, 8'h00);
    done("slave");
    final_report();
  end
endmodule
`default_nettype wire
